/* hdl/hs_int_slots.sv */
// Per-microframe slot handling of a high-speed interrupt transfer descriptor.
// Assumes microframe start, frame number and transaction answers come from
// logic on mclk; software reaches the descriptor over Avalon-MM.
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
`include "hs_int_slots_consts.svh"
module hs_int_slots (
  input wire logic mclk,
  input wire logic rst,
  input wire hs_int_slots_pkg::avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic uframe_start,
  input wire logic [10:0] frame_num,
  input wire logic [2:0] uframe_idx,
  input wire hs_int_slots_pkg::txn_rsp_t txn_rsp,
  output logic txn_req,
  output logic txn_dir_in,
  output logic irq
);
  import hs_int_slots_pkg::*;

  // All state lives in one struct, registered once per edge
  slot_state_t cur_ff; // Registered state
  slot_state_t nxt_cur; // Next state
  // Helper nets of the next-state logic
  logic [2:0] new_code; // Result code of the answering transaction
  logic frame_hit; // Descriptor frame matches bus frame
  logic bus_wr; // Write taken this edge
  logic bus_rd_start; // Read request first cycle
  logic [7:0] cleared_mask; // Mask after hardware clear

  // Result code of the current answer
  mf_result_enc u_enc (
    .dir_in(cur_ff.dir_in),
    .xact_err(txn_rsp.xact_err),
    .babble(txn_rsp.babble),
    .underrun(txn_rsp.underrun),
    .code(new_code)
  );

  // Frame test: zero field lets the mask alone decide
  assign frame_hit = (cur_ff.frame_sel == `FRAME_SEL_RST) ||
                     (cur_ff.frame_sel == frame_num[4:0]);
  // A write lands in the second request cycle, a read loads data in the first
  assign bus_wr = avs_req.write & cur_ff.ack;
  assign bus_rd_start = avs_req.read & ~cur_ff.ack;
  // Schedule with the serviced slot's bit removed
  assign cleared_mask = cur_ff.mask & ~(8'h01 << cur_ff.slot);

  // Next-state logic
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.ack = (avs_req.read | avs_req.write) & ~cur_ff.ack;
    // Read data captured in the first request cycle
    if (bus_rd_start)
    begin
      unique case (avs_req.address)
        `REG_CTRL:
        begin
          // Frame field, direction and valid
          nxt_cur.rdata = {24'h000000, cur_ff.frame_sel, 1'b0, cur_ff.dir_in, cur_ff.valid};
        end
        `REG_SCHED:
        begin
          // Schedule mask as it stands
          nxt_cur.rdata = {24'h000000, cur_ff.mask};
        end
        `REG_WORD5:
        begin
          // Byte counts: slot 2 low byte, then slots 1 and 0
          nxt_cur.rdata = {cur_ff.cnt2[7:0], cur_ff.cnt1, cur_ff.cnt0};
        end
        `REG_WORD4:
        begin
          // Result codes above the schedule mask
          nxt_cur.rdata = {cur_ff.codes, cur_ff.mask};
        end
        `REG_IRQ_STAT:
        begin
          // Sticky event flags
          nxt_cur.rdata = {29'h00000000, cur_ff.irq_stat};
        end
        `REG_IRQ_MASK:
        begin
          // Interrupt enables
          nxt_cur.rdata = {29'h00000000, cur_ff.irq_mask};
        end
        `REG_MF2_HI:
        begin
          // High nibble of the slot 2 count
          nxt_cur.rdata = {28'h0000000, cur_ff.cnt2[11:8]};
        end
        default:
        begin
          // Unmapped words read zero
          nxt_cur.rdata = 32'h00000000;
        end
      endcase
    end
    // Software writes at the acknowledging edge
    if (bus_wr)
    begin
      unique case (avs_req.address)
        `REG_CTRL:
        begin
          // Valid, direction and frame field
          nxt_cur.valid = avs_req.writedata[`CTRL_VALID_BIT];
          nxt_cur.dir_in = avs_req.writedata[`CTRL_DIR_IN_BIT];
          nxt_cur.frame_sel = avs_req.writedata[`CTRL_FRAME_MSB:`CTRL_FRAME_LSB];
        end
        `REG_IRQ_STAT:
        begin
          // Write one to clear
          nxt_cur.irq_stat = cur_ff.irq_stat & ~avs_req.writedata[2:0];
        end
        `REG_IRQ_MASK:
        begin
          // Interrupt mask, same layout as the status
          nxt_cur.irq_mask = avs_req.writedata[2:0];
        end
        default:
        begin
        end
      endcase
    end
    // Engine
    unique case (cur_ff.st)
      ST_IDLE:
      begin
        // Issue only in matching frame with the slot armed
        if (uframe_start && cur_ff.valid && frame_hit && cur_ff.mask[uframe_idx])
        begin
          // Remember which slot the answer belongs to
          nxt_cur.st = ST_BUSY;
          nxt_cur.slot = uframe_idx;
        end
      end
      ST_BUSY:
      begin
        if (txn_rsp.done)
        begin
          nxt_cur.st = ST_IDLE;
          nxt_cur.codes[cur_ff.slot] = new_code;
          unique case (cur_ff.slot)
            3'h0:
            begin
              nxt_cur.cnt0 = txn_rsp.bytes;
            end
            3'h1:
            begin
              nxt_cur.cnt1 = txn_rsp.bytes;
            end
            3'h2:
            begin
              nxt_cur.cnt2 = txn_rsp.bytes;
            end
            default:
            begin
            end
          endcase
          // Disarm the serviced slot
          nxt_cur.mask = cleared_mask;
          // Flags are set after any software clear above, so the set wins
          nxt_cur.irq_stat[`IRQ_SLOT_DONE] = 1'b1;
          if (new_code != 3'h0)
          begin
            nxt_cur.irq_stat[`IRQ_SLOT_ERR] = 1'b1;
          end
          // Retire on empty schedule or babble on IN
          if (cleared_mask == 8'h00 || (txn_rsp.babble && cur_ff.dir_in))
          begin
            nxt_cur.valid = 1'b0;
            nxt_cur.irq_stat[`IRQ_RETIRED] = 1'b1;
          end
        end
      end
    endcase
    // Software arming is an OR, so it can only raise bits and wins a clash
    if (bus_wr && avs_req.address == `REG_SCHED)
    begin
      nxt_cur.mask = nxt_cur.mask | avs_req.writedata[7:0];
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs
  assign avs_readdata = cur_ff.rdata;
  // One wait cycle on every access
  assign avs_waitrequest = (avs_req.read | avs_req.write) & ~cur_ff.ack;
  assign txn_req = (cur_ff.st == ST_BUSY);
  assign txn_dir_in = cur_ff.dir_in;
  // Level interrupt from unmasked status bits
  assign irq = |(cur_ff.irq_stat & cur_ff.irq_mask);

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Issue only with an armed slot in a matching frame
  issue_needs_mask_a: assert property (
    $rose(txn_req) |-> $past(cur_ff.mask[uframe_idx]) && $past(uframe_start))
    else $error("transaction issued without armed slot");
  issue_needs_frame_a: assert property (
    $rose(txn_req) |-> $past(frame_hit) && $past(cur_ff.valid))
    else $error("transaction issued outside matching frame");
  // Transaction request stands until its answer
  busy_hold_a: assert property (
    (txn_req && !txn_rsp.done) |=> txn_req)
    else $error("transaction request dropped early");

  // Serviced slot is disarmed, software arming is never undone
  mask_clear_a: assert property (
    (txn_req && txn_rsp.done && !bus_wr) |=> !cur_ff.mask[$past(cur_ff.slot)])
    else $error("serviced slot not cleared");
  arm_wins_a: assert property (
    (bus_wr && avs_req.address == `REG_SCHED) |=>
      (cur_ff.mask & $past(avs_req.writedata[7:0])) == $past(avs_req.writedata[7:0]))
    else $error("armed schedule bit lost");

  // Counts of slots 0 to 2 land in their fields
  cnt0_store_a: assert property (
    (txn_req && txn_rsp.done && cur_ff.slot == 3'h0) |=> cur_ff.cnt0 == $past(txn_rsp.bytes))
    else $error("microframe 0 count not stored");
  cnt1_store_a: assert property (
    (txn_req && txn_rsp.done && cur_ff.slot == 3'h1) |=> cur_ff.cnt1 == $past(txn_rsp.bytes))
    else $error("microframe 1 count not stored");
  cnt2_store_a: assert property (
    (txn_req && txn_rsp.done && cur_ff.slot == 3'h2) |=> cur_ff.cnt2 == $past(txn_rsp.bytes))
    else $error("microframe 2 count not stored");

  // Code bits follow the answer flags and the direction
  code_err_a: assert property (
    (txn_req && txn_rsp.done) |=>
      cur_ff.codes[$past(cur_ff.slot)][`RC_XACT_ERR] == $past(txn_rsp.xact_err))
    else $error("transaction error bit not recorded");
  code_babble_a: assert property (
    (txn_req && txn_rsp.done) |=> cur_ff.codes[$past(cur_ff.slot)][`RC_BABBLE] ==
      ($past(txn_rsp.babble) && $past(cur_ff.dir_in)))
    else $error("babble bit wrong for direction");
  code_dir_a: assert property (
    (txn_req && txn_rsp.done) |=> (cur_ff.codes[$past(cur_ff.slot)][`RC_UNDERRUN] == 1'b0) ||
      !$past(cur_ff.dir_in))
    else $error("underrun flagged on IN");
  // Codes and the slot 0 count stay put while no answer arrives
  code_hold_a: assert property (
    !(txn_req && txn_rsp.done) |=> $stable(cur_ff.codes) && $stable(cur_ff.cnt0))
    else $error("unserviced fields changed");

  // Retire on an empty schedule or on babble on IN
  retire_a: assert property (
    (txn_req && txn_rsp.done && cleared_mask == 8'h00 && !bus_wr) |=> !cur_ff.valid)
    else $error("valid not cleared after last slot");
  fatal_retire_a: assert property (
    (txn_req && txn_rsp.done && txn_rsp.babble && cur_ff.dir_in && !bus_wr) |=>
      !cur_ff.valid)
    else $error("valid not cleared after babble");
  // Done flag: a hardware set beats a same-edge software clear
  set_wins_a: assert property (
    (txn_req && txn_rsp.done) |=> cur_ff.irq_stat[`IRQ_SLOT_DONE])
    else $error("slot done flag lost");

  // Bus answers after one wait cycle
  bus_ack_a: assert property (
    (avs_req.read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("read answer late");
  write_ack_a: assert property (
    (avs_req.write && avs_waitrequest) |=> !avs_waitrequest)
    else $error("write answer late");

  // Main scenarios
  all_slots_c: cover property (cur_ff.mask == 8'hff ##1 txn_req);
  retire_c: cover property ($fell(cur_ff.valid));
  err_irq_c: cover property ($rose(irq));
  fatal_c: cover property (txn_req && txn_rsp.done && txn_rsp.babble && cur_ff.dir_in);
  arm_c: cover property (bus_wr && avs_req.address == `REG_SCHED);
endmodule
`default_nettype wire

/* hdl/hs_int_slots_consts.svh */
// Offsets, field positions and reset values for the interrupt slot block.
// Assumes word-indexed Avalon-MM addressing; included by bare name.
`ifndef HS_INT_SLOTS_CONSTS_SVH
`define HS_INT_SLOTS_CONSTS_SVH

// Register word indices
`define REG_CTRL 4'h0
`define REG_SCHED 4'h1
`define REG_WORD5 4'h2
`define REG_WORD4 4'h3
`define REG_IRQ_STAT 4'h4
`define REG_IRQ_MASK 4'h5
`define REG_MF2_HI 4'h6

// Control register fields
`define CTRL_VALID_BIT 0
`define CTRL_DIR_IN_BIT 1
`define CTRL_FRAME_LSB 3
`define CTRL_FRAME_MSB 7

// Result code bits per microframe
`define RC_XACT_ERR 0
`define RC_BABBLE 1
`define RC_UNDERRUN 2

// Interrupt status bits
`define IRQ_SLOT_DONE 0
`define IRQ_SLOT_ERR 1
`define IRQ_RETIRED 2

// Reset values
`define SCHED_RST 8'h00
`define FRAME_SEL_RST 5'h00
`define IRQ_MASK_RST 3'h0

`endif

/* hdl/hs_int_slots_pkg.sv */
// Types shared by the interrupt slot block.
// Assumes the consts header is compiled alongside.
`default_nettype none
package hs_int_slots_pkg;

  // Engine states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } eng_state_t;

  // Answer from the link engine for one transaction
  typedef struct packed {
    logic done;
    logic [11:0] bytes;
    logic xact_err;
    logic babble;
    logic underrun;
  } txn_rsp_t;

  // Avalon-MM request side
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avs_req_t;

  // Whole state of the slot block
  typedef struct packed {
    eng_state_t st;
    logic valid;
    logic dir_in;
    logic [4:0] frame_sel;
    logic [7:0] mask;
    logic [7:0][2:0] codes;
    logic [11:0] cnt0;
    logic [11:0] cnt1;
    logic [11:0] cnt2;
    logic [2:0] slot;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
  } slot_state_t;

endpackage
`default_nettype wire

/* hdl/mf_result_enc.sv */
// Encoder for one microframe result code.
// Assumes flags are valid in the cycle the transaction answer arrives.
`default_nettype none
`include "hs_int_slots_consts.svh"
module mf_result_enc (
  input wire logic dir_in,
  input wire logic xact_err,
  input wire logic babble,
  input wire logic underrun,
  output logic [2:0] code
);
  // Babble only counts on IN, underrun only on OUT
  always_comb
  begin
    code = 3'h0;
    code[`RC_XACT_ERR] = xact_err;
    code[`RC_BABBLE] = babble & dir_in;
    code[`RC_UNDERRUN] = underrun & ~dir_in;
  end
endmodule
`default_nettype wire

/* sim/int_endpoint_model.sv */
// Behavioural interrupt endpoint answering each transaction request of the slot block.
// Assumes txn_req holds until the answer is taken; the bench sets delay and answer.
`default_nettype none
module int_endpoint_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic txn_req,
  input wire logic [2:0] dly,
  input wire logic [11:0] ans_bytes,
  input wire logic [2:0] ans_flags,
  output hs_int_slots_pkg::txn_rsp_t txn_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  import hs_int_slots_pkg::*;
  logic [3:0] wait_cnt; // Cycles since the request rose
  // One done pulse per request; idle data lines toggle so stale values never match
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wait_cnt <= 4'h0;
      txn_rsp <= '0;
    end
    else
    begin
      if (txn_req && wait_cnt == {1'b0, dly})
        txn_rsp <= {1'b1, ans_bytes, ans_flags};
      else
        txn_rsp <= {1'b0, ~txn_rsp[14:0]};
      if (!txn_req)
        wait_cnt <= 4'h0;
      else if (wait_cnt <= {1'b0, dly})
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* sim/hs_interrupt_descriptor_slots_bench.sv */
// Self-checking bench for the interrupt descriptor slot block.
// Assumes the package and consts header are compiled first.
`default_nettype none
`include "hs_int_slots_consts.svh"
module hs_interrupt_descriptor_slots_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import hs_int_slots_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  avs_req_t avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic uframe_start = 1'b0;
  logic [10:0] frame_num = 11'h000;
  logic [2:0] uframe_idx = 3'h0;
  txn_rsp_t txn_rsp;
  logic txn_req;
  logic txn_dir_in;
  logic irq;
  logic [2:0] dly = 3'h3; // Endpoint answer delay
  logic [11:0] ans_bytes = 12'h000;
  logic [2:0] ans_flags = 3'h0; // Error, babble, underrun
  int fails = 0;
  int n_checks = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  hs_int_slots dut_u (.mclk(mclk), .rst(rst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .uframe_start(uframe_start), .frame_num(frame_num), .uframe_idx(uframe_idx),
    .txn_rsp(txn_rsp), .txn_req(txn_req), .txn_dir_in(txn_dir_in), .irq(irq));
  int_endpoint_model ep_u (.mclk(mclk), .rst(rst), .txn_req(txn_req), .dly(dly),
    .ans_bytes(ans_bytes), .ans_flags(ans_flags), .txn_rsp(txn_rsp));
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    avs_req <= '{address: a, read: !w, write: w, writedata: d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_req <= '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  // Interrupt level after the last write has landed
  task automatic ci(input logic e);
    repeat (2) @(posedge mclk);
    chk(irq, e);
  endtask
  // One microframe start; judge whether a transaction was issued
  task automatic mf(input logic [2:0] k, input logic e);
    logic seen;
    uframe_idx <= k;
    uframe_start <= 1'b1;
    ans_bytes <= 12'ha50 ^ {9'h0, k};
    @(posedge mclk);
    uframe_start <= 1'b0;
    seen = 1'b0;
    repeat (12)
    begin
      @(posedge mclk);
      if (txn_req === 1'b1)
        seen = 1'b1;
    end
    chk(seen, e);
  endtask
  // OUT with error and underrun on even microframes, then interrupt handling
  task automatic t_out();
    ans_flags <= 3'b111;
    wr(`REG_IRQ_MASK, 32'h7);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_SCHED, 32'h14);
    wr(`REG_SCHED, 32'h41);
    rd(`REG_SCHED, 32'h55);
    for (int k = 0; k < 8; k++)
      mf(k[2:0], !k[0]);
    rd(`REG_WORD5, {8'h52, 12'h000, 12'ha50});
    rd(`REG_MF2_HI, 32'ha);
    rd(`REG_WORD4, 32'h14514500);
    rd(`REG_CTRL, 32'h0);
    ci(1'b1);
    rd(`REG_IRQ_STAT, 32'h7);
    wr(`REG_IRQ_MASK, 32'h0);
    ci(1'b0);
    wr(`REG_IRQ_MASK, 32'h7);
    ci(1'b1);
    wr(`REG_IRQ_STAT, 32'h7);
    ci(1'b0);
  endtask
  // IN every microframe, gated by the frame field
  task automatic t_in();
    dly <= 3'h0;
    ans_flags <= 3'b000;
    frame_num <= 11'h405;
    wr(`REG_CTRL, 32'h1b);
    wr(`REG_SCHED, 32'hff);
    mf(3'h0, 1'b0);
    mf(3'h1, 1'b0);
    chk(txn_dir_in, 1'b1);
    frame_num <= 11'h7e3;
    for (int k = 0; k < 8; k++)
      mf(k[2:0], 1'b1);
    rd(`REG_WORD5, {8'h52, 12'ha51, 12'ha50});
    rd(`REG_WORD4, 32'h0);
    rd(`REG_CTRL, 32'h1a);
  endtask
  // Babble on IN retires the descriptor before the next armed microframe
  task automatic t_fatal();
    dly <= 3'h2;
    ans_flags <= 3'b011;
    wr(`REG_CTRL, 32'h1b);
    wr(`REG_SCHED, 32'h11);
    mf(3'h0, 1'b1);
    mf(3'h4, 1'b0);
    rd(`REG_WORD4, 32'h210);
    rd(`REG_CTRL, 32'h1a);
    rd(4'h7, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_out();
    t_in();
    t_fatal();
    conclude();
  end
  // Watchdog
  initial
  begin
    #40000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
